// ===== src/pfc_limit_trim_config_defs.svh
// offsets, field positions, reset values and timing counts of the limit/trim bank
// assumes a 40 MHz system clock; includers use the macros by name only
//
// Overview of operation
// - bit 7 of limit field picks polarity
// - limit code decodes to six microamp thresholds
// - bit 0 picks level shift reference
// - eight-bit read-write temperature hysteresis held
// - fault flag clears above limit plus hysteresis
// - warning flag clears above limit plus hysteresis
// - gain trim writable only while unlocked
// - trim bit 7 is correction polarity
// - trim magnitude calibrates line voltage gain
// - debounced overcurrent disables pwm rest of cycle
`ifndef PFC_LIMIT_TRIM_CONFIG_DEFS_SVH
`define PFC_LIMIT_TRIM_CONFIG_DEFS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_FAST_OC 16'hfe3e
`define IDX_TEMP_HYST 16'hfe3f
`define IDX_GAIN_TRIM 16'hfe40
`define IDX_LOCK 16'hfe60
`define IDX_FAULT_LIMIT 16'hfe61
`define IDX_WARN_LIMIT 16'hfe62
`define IDX_DEBOUNCE 16'hfe63
`define IDX_IRQ_STATUS 16'hfe64
`define IDX_IRQ_MASK 16'hfe65
`define IDX_LIVE_FLAGS 16'hfe66

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define FOC_POL_BIT 7
`define FOC_RANGE_BIT 1
`define FOC_REF_BIT 0
`define FOC_WRITE_MASK 8'he3
`define TRIM_POL_BIT 7
`define LOCK_OPEN_BIT 0
`define RESET_BYTE 8'h00
`define IRQ_TRIP_BIT 0
`define IRQ_FAULT_BIT 1
`define IRQ_WARN_BIT 2

// ----------------------------------------------------------------
// debounce times in ns and cycles at 25 ns, rounded up
// ----------------------------------------------------------------
`define CLOCK_PERIOD_NS 25
`define DEBOUNCE0_NS 40
`define DEBOUNCE1_NS 80
`define DEBOUNCE2_NS 120
`define DEBOUNCE3_NS 240
`define NS_TO_CYCLES(t) (((t) + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

`endif

// ===== src/pfc_limit_trim_config_pkg.sv
// types shared by the limit/trim configuration bank
// assumes the defs header supplies all numeric constants
`default_nettype none

package pfc_limit_trim_config_pkg;
  typedef logic [7:0] byte_type;
  typedef enum logic [1:0] {TRIP_IDLE, TRIP_COUNT, TRIP_HELD} trip_state_type;
endpackage

`default_nettype wire

// ===== src/pfc_limit_trim_config_regs.sv
// apb register bank for limit, range, hysteresis and gain trim settings
// assumes apb master, comparator and adc codes synchronous to CLOCK
//
// Added by the designer: the APB interface to the registers.
`include "pfc_limit_trim_config_defs.svh"
`default_nettype none

module pfc_limit_trim_config_regs (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [17:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [7:0] TEMPERATURE_SENSOR_CODE,
  input wire logic CS_ABOVE_LIMIT,
  input wire logic SWITCH_CYCLE_START,
  input wire logic [11:0] INPUT_LINE_VOLTAGE_CODE,
  output logic [11:0] INPUT_LINE_VOLTAGE_TRIMMED,
  output logic NEGATIVE_SENSING,
  output logic [6:0] CURRENT_LIMIT_THRESHOLD_UA,
  output logic LEVEL_SHIFT_REF_CHOICE,
  output logic CS_RANGE_500MV,
  output logic GAIN_TRIM_NEGATIVE,
  output logic [6:0] GAIN_TRIM_MAGNITUDE,
  output logic OVERTEMP_FAULT_FLAG,
  output logic OVERTEMP_WARNING_FLAG,
  output logic PWM_DISABLE,
  output logic IRQ
);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------

  // threshold in microamps from the three-bit limit code
  function automatic logic [6:0] limit_ua(input logic [2:0] code);
    logic [6:0] step;
    step = 7'({5'h00, code[1:0]} + 7'h01) * 7'h14;
    limit_ua = code[2] ? 7'(step + 7'h28) : step;
  endfunction

  // debounce select to a cycle count
  function automatic logic [3:0] debounce_cycles(input logic [1:0] sel);
    unique case (sel)
      2'h0: debounce_cycles = 4'(`NS_TO_CYCLES(`DEBOUNCE0_NS));
      2'h1: debounce_cycles = 4'(`NS_TO_CYCLES(`DEBOUNCE1_NS));
      2'h2: debounce_cycles = 4'(`NS_TO_CYCLES(`DEBOUNCE2_NS));
      2'h3: debounce_cycles = 4'(`NS_TO_CYCLES(`DEBOUNCE3_NS));
    endcase
  endfunction

  // reading above limit plus hysteresis, nine bits so no wrap
  function automatic logic above_release(input logic [7:0] reading,
                                         input logic [7:0] limit,
                                         input logic [7:0] hyst);
    above_release = {1'b0, reading} > ({1'b0, limit} + {1'b0, hyst});
  endfunction

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  pfc_limit_trim_config_pkg::byte_type fast_overcurrent_setting;
  pfc_limit_trim_config_pkg::byte_type temperature_hysteresis;
  pfc_limit_trim_config_pkg::byte_type input_voltage_adc_gain_trim;
  pfc_limit_trim_config_pkg::byte_type fault_limit;
  pfc_limit_trim_config_pkg::byte_type warn_limit;
  logic unlocked;
  logic [1:0] debounce_sel;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic overtemp_fault;
  logic overtemp_warn;
  logic pwm_off;
  logic [3:0] trip_count;
  pfc_limit_trim_config_pkg::trip_state_type trip_state;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------

  // index is the word address; low two bits must be zero
  wire logic [15:0] index = PADDR[17:2];
  wire logic aligned = PADDR[1:0] == 2'h0;
  wire logic access = PSEL && PENABLE && PREADY;
  wire logic wr = access && PWRITE;
  wire logic hit_fast = aligned && index == `IDX_FAST_OC;
  wire logic hit_hyst = aligned && index == `IDX_TEMP_HYST;
  wire logic hit_trim = aligned && index == `IDX_GAIN_TRIM;
  wire logic hit_lock = aligned && index == `IDX_LOCK;
  wire logic hit_flim = aligned && index == `IDX_FAULT_LIMIT;
  wire logic hit_wlim = aligned && index == `IDX_WARN_LIMIT;
  wire logic hit_deb = aligned && index == `IDX_DEBOUNCE;
  wire logic hit_stat = aligned && index == `IDX_IRQ_STATUS;
  wire logic hit_mask = aligned && index == `IDX_IRQ_MASK;
  wire logic hit_live = aligned && index == `IDX_LIVE_FLAGS;
  wire logic mapped = hit_fast || hit_hyst || hit_trim || hit_lock || hit_flim ||
                      hit_wlim || hit_deb || hit_stat || hit_mask || hit_live;
  wire logic trim_refused = PWRITE && hit_trim && !unlocked;
  wire logic next_error = !mapped || trim_refused;

  // read mux; reserved fields come back as zero
  wire logic [7:0] read_byte =
    hit_fast ? fast_overcurrent_setting :
    hit_hyst ? temperature_hysteresis :
    hit_trim ? input_voltage_adc_gain_trim :
    hit_lock ? {7'h00, unlocked} :
    hit_flim ? fault_limit :
    hit_wlim ? warn_limit :
    hit_deb ? {6'h00, debounce_sel} :
    hit_stat ? {5'h00, irq_status} :
    hit_mask ? {5'h00, irq_mask} :
    hit_live ? {5'h00, overtemp_warn, overtemp_fault, pwm_off} : 8'h00;

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h00000000;
    end else begin
      PREADY <= PSEL && PENABLE && !PREADY;
      PSLVERR <= PSEL && PENABLE && !PREADY && next_error;
      PRDATA <= (PSEL && PENABLE && !PREADY && !PWRITE && mapped) ?
                {24'h000000, read_byte} : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------

  // writes land only at the edge that completes the access
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      fast_overcurrent_setting <= `RESET_BYTE;
      temperature_hysteresis <= `RESET_BYTE;
      input_voltage_adc_gain_trim <= `RESET_BYTE;
      fault_limit <= `RESET_BYTE;
      warn_limit <= `RESET_BYTE;
      unlocked <= 1'b0;
      debounce_sel <= 2'h0;
      irq_mask <= 3'h0;
    end else begin
      if (wr && hit_fast) begin
        fast_overcurrent_setting <= PWDATA[7:0] & `FOC_WRITE_MASK;
      end
      if (wr && hit_hyst) begin
        temperature_hysteresis <= PWDATA[7:0];
      end
      if (wr && hit_trim && unlocked) begin
        input_voltage_adc_gain_trim <= PWDATA[7:0];
      end
      if (wr && hit_lock) begin
        unlocked <= PWDATA[`LOCK_OPEN_BIT];
      end
      if (wr && hit_flim) begin
        fault_limit <= PWDATA[7:0];
      end
      if (wr && hit_wlim) begin
        warn_limit <= PWDATA[7:0];
      end
      if (wr && hit_deb) begin
        debounce_sel <= PWDATA[1:0];
      end
      if (wr && hit_mask) begin
        irq_mask <= PWDATA[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // overtemperature flags
  // ----------------------------------------------------------------

  // sensor code falls as temperature rises, so below limit means hot
  wire logic fault_set = TEMPERATURE_SENSOR_CODE < fault_limit;
  wire logic warn_set = TEMPERATURE_SENSOR_CODE < warn_limit;
  wire logic fault_release = above_release(TEMPERATURE_SENSOR_CODE, fault_limit,
                                           temperature_hysteresis);
  wire logic warn_release = above_release(TEMPERATURE_SENSOR_CODE, warn_limit,
                                          temperature_hysteresis);
  wire logic fault_rise = fault_set && !overtemp_fault;
  wire logic warn_rise = warn_set && !overtemp_warn;

  // between the two thresholds the flag keeps its value
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      overtemp_fault <= 1'b0;
      overtemp_warn <= 1'b0;
    end else begin
      if (fault_set) begin
        overtemp_fault <= 1'b1;
      end else if (fault_release) begin
        overtemp_fault <= 1'b0;
      end
      if (warn_set) begin
        overtemp_warn <= 1'b1;
      end else if (warn_release) begin
        overtemp_warn <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // overcurrent debounce
  // ----------------------------------------------------------------
  wire logic [3:0] deb_len = debounce_cycles(debounce_sel);
  wire logic trip_now = trip_state == pfc_limit_trim_config_pkg::TRIP_COUNT &&
                        CS_ABOVE_LIMIT && trip_count >= deb_len;

  // debounce, trip, hold until cycle start
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      trip_state <= pfc_limit_trim_config_pkg::TRIP_IDLE;
      trip_count <= 4'h0;
      pwm_off <= 1'b0;
    end else begin
      unique case (trip_state)
        pfc_limit_trim_config_pkg::TRIP_IDLE: begin
          trip_count <= 4'h1;
          if (CS_ABOVE_LIMIT) begin
            trip_state <= pfc_limit_trim_config_pkg::TRIP_COUNT;
          end
        end
        pfc_limit_trim_config_pkg::TRIP_COUNT: begin
          trip_count <= 4'(trip_count + 4'h1);
          if (!CS_ABOVE_LIMIT) begin
            trip_state <= pfc_limit_trim_config_pkg::TRIP_IDLE;
          end else if (trip_now) begin
            trip_state <= pfc_limit_trim_config_pkg::TRIP_HELD;
            pwm_off <= 1'b1;
          end
        end
        pfc_limit_trim_config_pkg::TRIP_HELD: begin
          // a new switching cycle re-arms the trip and clears pwm_off
          if (SWITCH_CYCLE_START) begin
            trip_state <= pfc_limit_trim_config_pkg::TRIP_IDLE;
            pwm_off <= 1'b0;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and line
  // ----------------------------------------------------------------
  wire logic [2:0] events = {warn_rise, fault_rise, trip_now};
  wire logic [2:0] clear_bits = (wr && hit_stat) ? PWDATA[2:0] : 3'h0;
  // a new event in the clearing cycle survives the clear
  wire logic [2:0] next_status = (irq_status & ~clear_bits) | events;

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      irq_status <= 3'h0;
      IRQ <= 1'b0;
    end else begin
      irq_status <= next_status;
      IRQ <= |(next_status & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // gain trim applied to the line voltage sample
  // ----------------------------------------------------------------

  // correction is code * magnitude / 1024, about +-12 percent full scale
  wire logic [18:0] product = INPUT_LINE_VOLTAGE_CODE * input_voltage_adc_gain_trim[6:0];
  wire logic [12:0] correction = {4'h0, product[18:10]};
  wire logic [12:0] base = {1'b0, INPUT_LINE_VOLTAGE_CODE};
  wire logic [12:0] plus = base + correction;
  wire logic [12:0] minus = base - correction;
  wire logic [11:0] next_trimmed = input_voltage_adc_gain_trim[`TRIM_POL_BIT] ?
                                   minus[11:0] : (plus[12] ? 12'hfff : plus[11:0]);

  // ----------------------------------------------------------------
  // registered configuration outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      NEGATIVE_SENSING <= 1'b0;
      CURRENT_LIMIT_THRESHOLD_UA <= 7'h00;
      LEVEL_SHIFT_REF_CHOICE <= 1'b0;
      CS_RANGE_500MV <= 1'b0;
      GAIN_TRIM_NEGATIVE <= 1'b0;
      GAIN_TRIM_MAGNITUDE <= 7'h00;
      INPUT_LINE_VOLTAGE_TRIMMED <= 12'h000;
      OVERTEMP_FAULT_FLAG <= 1'b0;
      OVERTEMP_WARNING_FLAG <= 1'b0;
      PWM_DISABLE <= 1'b0;
    end else begin
      NEGATIVE_SENSING <= fast_overcurrent_setting[`FOC_POL_BIT];
      CURRENT_LIMIT_THRESHOLD_UA <= limit_ua(fast_overcurrent_setting[7:5]);
      LEVEL_SHIFT_REF_CHOICE <= fast_overcurrent_setting[`FOC_REF_BIT];
      CS_RANGE_500MV <= fast_overcurrent_setting[`FOC_RANGE_BIT];
      GAIN_TRIM_NEGATIVE <= input_voltage_adc_gain_trim[`TRIM_POL_BIT];
      GAIN_TRIM_MAGNITUDE <= input_voltage_adc_gain_trim[6:0];
      INPUT_LINE_VOLTAGE_TRIMMED <= next_trimmed;
      OVERTEMP_FAULT_FLAG <= overtemp_fault;
      OVERTEMP_WARNING_FLAG <= overtemp_warn;
      PWM_DISABLE <= pwm_off;
    end
  end

endmodule // pfc_limit_trim_config_regs

`default_nettype wire

// ===== tb/pfc_limit_trim_config_regs_assertions.sv
// concurrent checks on the ports of the limit/trim register bank
// assumes one rising-edge clock and synchronous active-low reset
`default_nettype none

module pfc_limit_trim_config_regs_assertions (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic CS_ABOVE_LIMIT,
  input wire logic SWITCH_CYCLE_START,
  input wire logic NEGATIVE_SENSING,
  input wire logic [6:0] CURRENT_LIMIT_THRESHOLD_UA,
  input wire logic GAIN_TRIM_NEGATIVE,
  input wire logic [6:0] GAIN_TRIM_MAGNITUDE,
  input wire logic PWM_DISABLE
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  // accepted write, the only cause of a trim change
  wire logic write_done = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
  // ----------------------------------------
  // apb handshake
  // ----------------------------------------
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_one_wait;
    !PREADY ##1 PREADY;
  endsequence
  a_ready_one_wait: assert property (s_setup |=> s_one_wait)
    else $error("ready not in second access cycle");
  a_ready_one_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  a_error_with_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  a_rdata_quiet: assert property (PRDATA[31:8] == 24'h0 && (PREADY || PRDATA == 32'h0))
    else $error("read data outside ready or wide");
  // ----------------------------------------
  // decoded settings and protection
  // ----------------------------------------
  a_limit_positive: assert property (
    $past(NRST) && !NEGATIVE_SENSING |-> CURRENT_LIMIT_THRESHOLD_UA inside {20, 40, 60, 80})
    else $error("positive limit code off table");
  a_limit_negative: assert property (
    NEGATIVE_SENSING |-> CURRENT_LIMIT_THRESHOLD_UA inside {60, 80, 100, 120})
    else $error("negative limit code off table");
  // a trip needs the comparator high on consecutive samples first
  a_pwm_debounce: assert property (
    $rose(PWM_DISABLE) |-> $past(CS_ABOVE_LIMIT, 2) && $past(CS_ABOVE_LIMIT, 3))
    else $error("pwm disabled without debounced overcurrent");
  a_pwm_release: assert property (
    $fell(PWM_DISABLE) |-> $past(SWITCH_CYCLE_START, 2) || $past(SWITCH_CYCLE_START, 3))
    else $error("pwm released before cycle start");
  a_trim_written: assert property (
    $changed({GAIN_TRIM_NEGATIVE, GAIN_TRIM_MAGNITUDE}) |-> $past(write_done, 2))
    else $error("trim changed without accepted write");
endmodule // pfc_limit_trim_config_regs_assertions

bind pfc_limit_trim_config_regs pfc_limit_trim_config_regs_assertions i_checker (
  .CLOCK(CLOCK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .CS_ABOVE_LIMIT(CS_ABOVE_LIMIT),
  .SWITCH_CYCLE_START(SWITCH_CYCLE_START), .NEGATIVE_SENSING(NEGATIVE_SENSING),
  .CURRENT_LIMIT_THRESHOLD_UA(CURRENT_LIMIT_THRESHOLD_UA),
  .GAIN_TRIM_NEGATIVE(GAIN_TRIM_NEGATIVE), .GAIN_TRIM_MAGNITUDE(GAIN_TRIM_MAGNITUDE),
  .PWM_DISABLE(PWM_DISABLE)
);

`default_nettype wire

// ===== tb/tb_pfc_limit_trim_config_regs.sv
// self-checking bench for the limit/trim register bank
// assumes the bank answers apb with one wait state and lags outputs one clock
`include "pfc_limit_trim_config_defs.svh"
`default_nettype none

module tb_pfc_limit_trim_config_regs;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] wr; logic [6:0] ua;} row_type;
  logic CLOCK = 1'b0;
  logic NRST = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [17:0] PADDR = 18'h0;
  logic [31:0] PWDATA = 32'h0;
  logic [7:0] TEMPERATURE_SENSOR_CODE = 8'hff;
  logic CS_ABOVE_LIMIT = 1'b0;
  logic SWITCH_CYCLE_START = 1'b0;
  logic [11:0] INPUT_LINE_VOLTAGE_CODE = 12'h400;
  logic [31:0] PRDATA;
  logic [11:0] INPUT_LINE_VOLTAGE_TRIMMED;
  logic [6:0] CURRENT_LIMIT_THRESHOLD_UA, GAIN_TRIM_MAGNITUDE;
  logic PREADY, PSLVERR, NEGATIVE_SENSING, LEVEL_SHIFT_REF_CHOICE, CS_RANGE_500MV;
  logic GAIN_TRIM_NEGATIVE, OVERTEMP_FAULT_FLAG, OVERTEMP_WARNING_FLAG, PWM_DISABLE, IRQ;
  int err_count = 0;
  int samples_checked = 0;
  // bits 4:2 set in every row to show they are dropped
  row_type rows[8] = '{'{8'h1d, 7'h14}, '{8'h3e, 7'h28}, '{8'h5f, 7'h3c}, '{8'h7c, 7'h50},
    '{8'h9d, 7'h3c}, '{8'hbe, 7'h50}, '{8'hdf, 7'h64}, '{8'hfc, 7'h78}};

  always #12.5 CLOCK = ~CLOCK;

  pfc_limit_trim_config_regs i_dut (.CLOCK(CLOCK), .NRST(NRST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .TEMPERATURE_SENSOR_CODE(TEMPERATURE_SENSOR_CODE),
    .CS_ABOVE_LIMIT(CS_ABOVE_LIMIT), .SWITCH_CYCLE_START(SWITCH_CYCLE_START),
    .INPUT_LINE_VOLTAGE_CODE(INPUT_LINE_VOLTAGE_CODE),
    .INPUT_LINE_VOLTAGE_TRIMMED(INPUT_LINE_VOLTAGE_TRIMMED),
    .NEGATIVE_SENSING(NEGATIVE_SENSING), .CURRENT_LIMIT_THRESHOLD_UA(CURRENT_LIMIT_THRESHOLD_UA),
    .LEVEL_SHIFT_REF_CHOICE(LEVEL_SHIFT_REF_CHOICE), .CS_RANGE_500MV(CS_RANGE_500MV),
    .GAIN_TRIM_NEGATIVE(GAIN_TRIM_NEGATIVE), .GAIN_TRIM_MAGNITUDE(GAIN_TRIM_MAGNITUDE),
    .OVERTEMP_FAULT_FLAG(OVERTEMP_FAULT_FLAG), .OVERTEMP_WARNING_FLAG(OVERTEMP_WARNING_FLAG),
    .PWM_DISABLE(PWM_DISABLE), .IRQ(IRQ));

  // ----------------------------------------
  // stimulus and compare tasks
  // ----------------------------------------
  task automatic finish_test;
    if (err_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge CLOCK);
  endtask

  // one apb transfer; request held until ready is sampled high
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] d,
                     input logic [7:0] exp_d, input logic exp_err);
    int n;
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= {idx, 2'b00};
    PWDATA <= {24'h0, d};
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    for (n = 0; n < 20 && PREADY !== 1'b1; n++) @(posedge CLOCK);
    if (PREADY !== 1'b1) begin
      err_count++;
      finish_test;
    end
    check(PSLVERR, exp_err);
    if (!wr) check(PRDATA, {24'h0, exp_d});
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic set_temp(input logic [7:0] c, input logic f, input logic w);
    @(posedge CLOCK);
    TEMPERATURE_SENSOR_CODE <= c;
    cyc(4);
    check({OVERTEMP_FAULT_FLAG, OVERTEMP_WARNING_FLAG}, {f, w});
  endtask

  // comparator high for exactly n samples, then a quiet gap
  task automatic cs_burst(input int n, input logic exp);
    @(posedge CLOCK);
    CS_ABOVE_LIMIT <= 1'b1;
    cyc(n);
    CS_ABOVE_LIMIT <= 1'b0;
    cyc(3);
    check(PWM_DISABLE, exp);
  endtask

  task automatic cycle_start;
    @(posedge CLOCK);
    SWITCH_CYCLE_START <= 1'b1;
    @(posedge CLOCK);
    SWITCH_CYCLE_START <= 1'b0;
    cyc(3);
  endtask

  initial begin
    repeat (20000) @(posedge CLOCK);
    err_count++;
    finish_test;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    cyc(3);
    NRST <= 1'b1;
    cyc(2);
    check(CURRENT_LIMIT_THRESHOLD_UA, 7'h14);
    foreach (rows[i]) begin
      apb(1'b1, `IDX_FAST_OC, rows[i].wr, 8'h00, 1'b0);
      apb(1'b0, `IDX_FAST_OC, 8'h00, rows[i].wr & 8'he3, 1'b0);
      check({NEGATIVE_SENSING, CURRENT_LIMIT_THRESHOLD_UA}, {rows[i].wr[7], rows[i].ua});
      check({CS_RANGE_500MV, LEVEL_SHIFT_REF_CHOICE}, rows[i].wr[1:0]);
    end
    apb(1'b1, `IDX_GAIN_TRIM, 8'h85, 8'h00, 1'b1);
    apb(1'b0, `IDX_GAIN_TRIM, 8'h00, 8'h00, 1'b0);
    apb(1'b1, `IDX_LOCK, 8'h01, 8'h00, 1'b0);
    apb(1'b1, `IDX_GAIN_TRIM, 8'h85, 8'h00, 1'b0);
    apb(1'b0, `IDX_GAIN_TRIM, 8'h00, 8'h85, 1'b0);
    cyc(3);
    check({GAIN_TRIM_NEGATIVE, GAIN_TRIM_MAGNITUDE}, 8'h85);
    check(INPUT_LINE_VOLTAGE_TRIMMED, 12'h3fb);
    apb(1'b1, `IDX_GAIN_TRIM, 8'h05, 8'h00, 1'b0);
    cyc(3);
    check(INPUT_LINE_VOLTAGE_TRIMMED, 12'h405);
    // full-scale code with largest trim: clamp on plus, no wrap on minus
    INPUT_LINE_VOLTAGE_CODE <= 12'hfff;
    apb(1'b1, `IDX_GAIN_TRIM, 8'h7f, 8'h00, 1'b0);
    cyc(3);
    check(INPUT_LINE_VOLTAGE_TRIMMED, 12'hfff);
    apb(1'b1, `IDX_GAIN_TRIM, 8'hff, 8'h00, 1'b0);
    cyc(3);
    check(INPUT_LINE_VOLTAGE_TRIMMED, 12'he04);
    apb(1'b1, 16'hfe50, 8'h11, 8'h00, 1'b1);
    apb(1'b1, `IDX_TEMP_HYST, 8'ha5, 8'h00, 1'b0);
    apb(1'b0, `IDX_TEMP_HYST, 8'h00, 8'ha5, 1'b0);
    apb(1'b1, `IDX_TEMP_HYST, 8'h10, 8'h00, 1'b0);
    apb(1'b1, `IDX_FAULT_LIMIT, 8'h40, 8'h00, 1'b0);
    apb(1'b1, `IDX_IRQ_MASK, 8'h07, 8'h00, 1'b0);
    set_temp(8'h30, 1'b1, 1'b0);
    set_temp(8'h50, 1'b1, 1'b0);
    set_temp(8'h51, 1'b0, 1'b0);
    check(IRQ, 1'b1);
    apb(1'b0, `IDX_IRQ_STATUS, 8'h00, 8'h02, 1'b0);
    apb(1'b1, `IDX_IRQ_STATUS, 8'h02, 8'h00, 1'b0);
    apb(1'b1, `IDX_WARN_LIMIT, 8'h60, 8'h00, 1'b0);
    set_temp(8'h70, 1'b0, 1'b1);
    set_temp(8'h71, 1'b0, 1'b0);
    apb(1'b0, `IDX_IRQ_STATUS, 8'h00, 8'h04, 1'b0);
    apb(1'b1, `IDX_IRQ_STATUS, 8'h04, 8'h00, 1'b0);
    apb(1'b1, `IDX_IRQ_MASK, 8'h06, 8'h00, 1'b0);
    cs_burst(2, 1'b0);
    cs_burst(3, 1'b1);
    check(IRQ, 1'b0);
    cycle_start;
    check(PWM_DISABLE, 1'b0);
    apb(1'b1, `IDX_IRQ_MASK, 8'h07, 8'h00, 1'b0);
    // mask lands at the ready edge, the line follows one clock later
    cyc(2);
    check(IRQ, 1'b1);
    apb(1'b1, `IDX_DEBOUNCE, 8'h03, 8'h00, 1'b0);
    cs_burst(10, 1'b0);
    cs_burst(11, 1'b1);
    cycle_start;
    // the two middle debounce settings: 4 and 5 counting cycles
    apb(1'b1, `IDX_DEBOUNCE, 8'h01, 8'h00, 1'b0);
    cs_burst(4, 1'b0);
    cs_burst(5, 1'b1);
    cycle_start;
    apb(1'b1, `IDX_DEBOUNCE, 8'h02, 8'h00, 1'b0);
    cs_burst(5, 1'b0);
    cs_burst(6, 1'b1);
    cycle_start;
    check(PWM_DISABLE, 1'b0);
    NRST <= 1'b0;
    cyc(3);
    NRST <= 1'b1;
    apb(1'b0, `IDX_TEMP_HYST, 8'h00, 8'h00, 1'b0);
    apb(1'b0, `IDX_LOCK, 8'h00, 8'h00, 1'b0);
    check({NEGATIVE_SENSING, CURRENT_LIMIT_THRESHOLD_UA}, 8'h14);
    finish_test;
  end
endmodule // tb_pfc_limit_trim_config_regs

`default_nettype wire
